// ==== rtl/srsr_result_status_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "srsr_defines.svh"

module srsr_result_status_regs
  import srsr_pkg::*;
(
  // clock, reset, enable
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // byte register port from the serial-bus engine
  input wire logic [7:0] regAddr,
  input wire srsr_pkg::srsr_byte_t regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output srsr_pkg::srsr_byte_t regRdData,
  output logic regRdValid,
  // measurement results from the conversion engine
  input wire logic resultValid,
  input wire srsr_pkg::srsr_chan_e resultChannel,
  input wire logic [15:0] resultWord,
  // power state from the sequencer
  input wire srsr_pkg::srsr_pwr_e powerState,
  // parameter commands from the command decoder
  input wire logic cmdValid,
  input wire srsr_pkg::srsr_op_e cmdOp,
  input wire logic [`SRSR_PARAM_AW-1:0] cmdParamOffset,
  input wire srsr_pkg::srsr_byte_t cmdData,
  output logic cmdReady,
  // applied configuration
  output srsr_pkg::srsr_byte_t apply_bus_addr_cmd,
  output srsr_pkg::srsr_byte_t channelEnableList
);
  import srsr_pkg::*;

  typedef struct packed {
    srsr_byte_t prox3Low;
    srsr_byte_t prox3High;
    srsr_byte_t auxLow;
    srsr_byte_t auxHigh;
    srsr_byte_t mailbox;
    srsr_byte_t chipState;
    logic [3:0][7:0] key;
    srsr_byte_t rdData;
    logic rdValid;
    srsr_byte_t apply_bus_addr_cmd;
    srsr_byte_t chanList;
    srsr_seq_e seq;
    logic cmdReady;
  } srsr_regs_s;

  srsr_regs_s regs_reg;
  srsr_regs_s regs_next;

  // one-hot view of which mapped byte an address selects
  typedef struct packed {
    logic prox3Low;
    logic prox3High;
    logic auxLow;
    logic auxHigh;
    logic mailbox;
    logic chipState;
    logic [3:0] key;
  } srsr_sel_s;

  // parameter memory handshake
  logic ramWrEn;
  logic ramRdEn;
  srsr_byte_t ramRdData;
  logic ramRdValid;
  srsr_byte_t ramBusAddr;
  srsr_byte_t ramChanList;

  // whether an address selects key byte idx
  function automatic logic keyHit(input logic [7:0] addr, input int idx);
    keyHit = (addr == 8'(`SRSR_OFF_KEY_B0 - idx));
  endfunction

  // shared by the read and write paths so both agree on the map
  function automatic srsr_sel_s decodeAddr(input logic [7:0] addr);
    srsr_sel_s sel;
    sel = '0;
    sel.prox3Low = (addr == `SRSR_OFF_PROX3_LOW);
    sel.prox3High = (addr == `SRSR_OFF_PROX3_HIGH);
    sel.auxLow = (addr == `SRSR_OFF_AUX_LOW);
    sel.auxHigh = (addr == `SRSR_OFF_AUX_HIGH);
    sel.mailbox = (addr == `SRSR_OFF_MAILBOX);
    sel.chipState = (addr == `SRSR_OFF_CHIP_STATE);
    for (int i = 0; i < 4; i++) begin
      sel.key[i] = keyHit(addr, i);
    end
    return sel;
  endfunction

  // read multiplexer over the mapped bytes; unmapped reads give zero
  function automatic srsr_byte_t readByte(input srsr_sel_s sel, input srsr_regs_s st);
    srsr_byte_t val;
    val = `SRSR_UNMAPPED_BYTE;
    if (sel.prox3Low) begin
      val = st.prox3Low;
    end
    if (sel.prox3High) begin
      val = st.prox3High;
    end
    if (sel.auxLow) begin
      val = st.auxLow;
    end
    if (sel.auxHigh) begin
      val = st.auxHigh;
    end
    if (sel.mailbox) begin
      val = st.mailbox;
    end
    if (sel.chipState) begin
      val = st.chipState;
    end
    for (int i = 0; i < 4; i++) begin
      if (sel.key[i]) begin
        val = st.key[i];
      end
    end
    return val;
  endfunction

  // state byte for a power state; an unknown code reads as all zero
  function automatic srsr_byte_t stateByte(input srsr_pwr_e pwr);
    srsr_byte_t val;
    val = `SRSR_RESET_BYTE;
    case (pwr)
      SRSR_PWR_RUNNING: begin
        val[`SRSR_STATE_RUNNING_BIT] = 1'b1;
      end
      SRSR_PWR_SUSPEND: begin
        val[`SRSR_STATE_SUSPEND_BIT] = 1'b1;
      end
      SRSR_PWR_SLEEP: begin
        val[`SRSR_STATE_SLEEP_BIT] = 1'b1;
      end
      default: begin
        val = `SRSR_RESET_BYTE;
      end
    endcase
    return val;
  endfunction

  // address decode of the current host access
  srsr_sel_s hostSel;
  assign hostSel = decodeAddr(regAddr);

  // one write strobe per key byte
  logic [3:0] keyWrEn;
  for (genvar g = 0; g < 4; g++) begin : gen_key_wr
    assign keyWrEn[g] = regWrEn && hostSel.key[g];
  end

  srsr_param_ram u_param_ram (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .wrEn(ramWrEn),
    .rdEn(ramRdEn),
    .addr(cmdParamOffset),
    .wrData(cmdData),
    .rdData(ramRdData),
    .rdValid(ramRdValid),
    .busAddrParam(ramBusAddr),
    .chanListParam(ramChanList)
  );

  // parameter accesses only through commands, one at a time
  always_comb begin
    ramWrEn = 1'b0;
    ramRdEn = 1'b0;
    if (regs_reg.seq == SRSR_SEQ_IDLE && cmdValid) begin
      case (cmdOp)
        SRSR_OP_GET: ramRdEn = 1'b1;
        SRSR_OP_WRITE: ramWrEn = 1'b1;
        default: begin
          // apply reads the live word, so it needs no memory access
          ramWrEn = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    regs_next = regs_reg;
    regs_next.rdValid = 1'b0;

    // host writes; state register is not in this decode
    if (regWrEn) begin
      if (hostSel.prox3Low) begin
        regs_next.prox3Low = regWrData;
      end
      if (hostSel.prox3High) begin
        regs_next.prox3High = regWrData;
      end
      if (hostSel.auxLow) begin
        regs_next.auxLow = regWrData;
      end
      if (hostSel.auxHigh) begin
        regs_next.auxHigh = regWrData;
      end
      if (hostSel.mailbox) begin
        regs_next.mailbox = regWrData;
      end
      // key bytes only store; nothing downstream reads them
      for (int i = 0; i < 4; i++) begin
        if (keyWrEn[i]) begin
          regs_next.key[i] = regWrData;
        end
      end
    end

    // a finishing measurement beats a same-cycle host write
    if (resultValid) begin
      case (resultChannel)
        SRSR_CH_PROX3: begin
          regs_next.prox3Low = resultWord[7:0];
          regs_next.prox3High = resultWord[15:8];
        end
        SRSR_CH_AUX: begin
          regs_next.auxLow = resultWord[7:0];
          regs_next.auxHigh = resultWord[15:8];
        end
        default: begin
          // unknown code: a same-cycle host write still lands
          regs_next.auxLow = regs_next.auxLow;
        end
      endcase
    end

    // read-only state view, reserved bits zero
    regs_next.chipState = stateByte(powerState);

    // channel list follows the memory; checking non-zero is the host's job
    regs_next.chanList = ramChanList;

    case (regs_reg.seq)
      SRSR_SEQ_IDLE: begin
        if (cmdValid) begin
          case (cmdOp)
            SRSR_OP_GET: regs_next.seq = SRSR_SEQ_WAIT;
            SRSR_OP_WRITE: regs_next.mailbox = cmdData;
            SRSR_OP_APPLY_ADDR: regs_next.apply_bus_addr_cmd = ramBusAddr;
            default: begin
              regs_next.seq = SRSR_SEQ_IDLE;
            end
          endcase
        end
      end
      SRSR_SEQ_WAIT: begin
        // further commands are refused until the memory answers
        if (ramRdValid) begin
          regs_next.mailbox = ramRdData;
          regs_next.seq = SRSR_SEQ_IDLE;
        end
      end
      default: begin
        regs_next.seq = SRSR_SEQ_IDLE;
      end
    endcase

    // registered copy so the ready output comes from a flop
    regs_next.cmdReady = (regs_next.seq == SRSR_SEQ_IDLE);

    // read data reflects the state before this cycle's updates
    if (regRdEn) begin
      regs_next.rdData = readByte(hostSel, regs_reg);
      regs_next.rdValid = 1'b1;
    end
  end

  // ce low holds every flop, the parameter memory included
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      regs_reg <= '0;
      regs_reg.seq <= SRSR_SEQ_IDLE;
      regs_reg.cmdReady <= 1'b1;
    end else if (ce) begin
      regs_reg <= regs_next;
    end
  end

  assign regRdData = regs_reg.rdData;
  assign regRdValid = regs_reg.rdValid;
  assign cmdReady = regs_reg.cmdReady;
  assign apply_bus_addr_cmd = regs_reg.apply_bus_addr_cmd;
  assign channelEnableList = regs_reg.chanList;

endmodule

`default_nettype wire

// ==== rtl/srsr_defines.svh ====
`ifndef SRSR_DEFINES_SVH
`define SRSR_DEFINES_SVH

// host-visible byte offsets
`define SRSR_OFF_PROX3_LOW 8'h2a
`define SRSR_OFF_PROX3_HIGH 8'h2b
`define SRSR_OFF_AUX_LOW 8'h2c
`define SRSR_OFF_AUX_HIGH 8'h2d
`define SRSR_OFF_MAILBOX 8'h2e
`define SRSR_OFF_CHIP_STATE 8'h30
`define SRSR_OFF_KEY_B3 8'h3b
`define SRSR_OFF_KEY_B2 8'h3c
`define SRSR_OFF_KEY_B1 8'h3d
`define SRSR_OFF_KEY_B0 8'h3e

// reset and unmapped read value
`define SRSR_RESET_BYTE 8'h00
`define SRSR_UNMAPPED_BYTE 8'h00

// chip state bit positions
`define SRSR_STATE_SLEEP_BIT 0
`define SRSR_STATE_SUSPEND_BIT 1
`define SRSR_STATE_RUNNING_BIT 2

// parameter memory
`define SRSR_PARAM_AW 5
`define SRSR_PARAM_DEPTH 32
`define SRSR_PARAM_BUS_ADDR 5'h00
`define SRSR_PARAM_CHAN_LIST 5'h01

`endif

// ==== rtl/srsr_pkg.sv ====
package srsr_pkg;

  // commands from the command decoder
  typedef enum logic [2:0] {
    SRSR_OP_GET = 3'b001,
    SRSR_OP_WRITE = 3'b010,
    SRSR_OP_APPLY_ADDR = 3'b100
  } srsr_op_e;

  // power state reported by the sequencer
  typedef enum logic [2:0] {
    SRSR_PWR_SLEEP = 3'b001,
    SRSR_PWR_SUSPEND = 3'b010,
    SRSR_PWR_RUNNING = 3'b100
  } srsr_pwr_e;

  // which 16-bit result a measurement delivers
  typedef enum logic [1:0] {
    SRSR_CH_PROX3 = 2'b01,
    SRSR_CH_AUX = 2'b10
  } srsr_chan_e;

  // command sequencer
  typedef enum logic [1:0] {
    SRSR_SEQ_IDLE = 2'b01,
    SRSR_SEQ_WAIT = 2'b10
  } srsr_seq_e;

  typedef logic [7:0] srsr_byte_t;

endpackage

// ==== rtl/srsr_param_ram.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "srsr_defines.svh"

module srsr_param_ram
  import srsr_pkg::*;
(
  // clock, reset and enable
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // access from the command sequencer
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [`SRSR_PARAM_AW-1:0] addr,
  input wire srsr_pkg::srsr_byte_t wrData,
  output srsr_pkg::srsr_byte_t rdData,
  output logic rdValid,
  // live parameter values
  output srsr_pkg::srsr_byte_t busAddrParam,
  output srsr_pkg::srsr_byte_t chanListParam
);
  import srsr_pkg::*;

  typedef struct packed {
    logic [`SRSR_PARAM_DEPTH-1:0][7:0] mem;
    srsr_byte_t rdData;
    logic rdValid;
  } srsr_ram_s;

  srsr_ram_s ram_reg;
  srsr_ram_s ram_next;

  // no bus address reaches this array; only the sequencer ports do
  always_comb begin
    ram_next = ram_reg;
    ram_next.rdValid = 1'b0;
    if (wrEn) begin
      ram_next.mem[addr] = wrData;
    end
    if (rdEn) begin
      ram_next.rdData = ram_reg.mem[addr];
      ram_next.rdValid = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ram_reg <= '0;
    end else if (ce) begin
      ram_reg <= ram_next;
    end
  end

  assign rdData = ram_reg.rdData;
  assign rdValid = ram_reg.rdValid;
  assign busAddrParam = ram_reg.mem[`SRSR_PARAM_BUS_ADDR];
  assign chanListParam = ram_reg.mem[`SRSR_PARAM_CHAN_LIST];

endmodule

`default_nettype wire

// ==== tb/srsr_checker_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module srsr_checker
  import srsr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire srsr_pkg::srsr_byte_t regRdData,
  input wire logic regRdValid,
  // results, state, commands
  input wire logic resultValid,
  input wire srsr_pkg::srsr_chan_e resultChannel,
  input wire logic [15:0] resultWord,
  input wire srsr_pkg::srsr_pwr_e powerState,
  input wire logic cmdValid,
  input wire srsr_pkg::srsr_op_e cmdOp,
  input wire logic [4:0] cmdParamOffset,
  input wire srsr_pkg::srsr_byte_t cmdData,
  input wire logic cmdReady,
  input wire srsr_pkg::srsr_byte_t apply_bus_addr_cmd
);
  import srsr_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_auxRes; resultValid && resultChannel == SRSR_CH_AUX; endsequence
  sequence s_rdAuxHigh; regRdEn && regAddr == 8'h2d && !regWrEn && !resultValid; endsequence
  sequence s_wrAddr; cmdValid && cmdReady && cmdOp == SRSR_OP_WRITE && cmdParamOffset == 5'h00; endsequence
  sequence s_apply; cmdValid && cmdOp == SRSR_OP_APPLY_ADDR; endsequence
  property p_rdValid; regRdEn |=> regRdValid; endproperty
  property p_noValid; !regRdEn |=> !regRdValid; endproperty
  property p_auxHigh; s_auxRes ##1 s_rdAuxHigh |=> {8'h00, regRdData} == $past(resultWord, 2) >> 8; endproperty
  // state register lags the sequencer by one cycle
  property p_state; regRdEn && regAddr == 8'h30 && !$past(rst) |=> regRdData == {5'h00, $past(powerState, 2)};
  endproperty
  property p_unmapped; regRdEn && (regAddr == 8'h2f || regAddr == 8'h01) |=> regRdData == 8'h00; endproperty
  property p_get; cmdValid && cmdReady && cmdOp == SRSR_OP_GET |=> !cmdReady ##1 cmdReady; endproperty
  property p_apply; s_wrAddr ##1 s_apply |=> apply_bus_addr_cmd == $past(cmdData, 2); endproperty
  property p_addrHold; !(cmdValid && cmdOp == SRSR_OP_APPLY_ADDR) |=> $stable(apply_bus_addr_cmd); endproperty
  a_rdValid: assert property (p_rdValid) else $error("read gave no valid");
  a_noValid: assert property (p_noValid) else $error("valid without read");
  a_auxHigh: assert property (p_auxHigh) else $error("aux high byte wrong");
  a_state: assert property (p_state) else $error("state byte wrong");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_get: assert property (p_get) else $error("query timing wrong");
  a_apply: assert property (p_apply) else $error("bus address not applied");
  a_addrHold: assert property (p_addrHold) else $error("bus address moved");
endmodule
bind srsr_result_status_regs srsr_checker u_srsr_checker(.clock, .rst, .regAddr, .regWrEn, .regRdEn,
  .regRdData, .regRdValid, .resultValid, .resultChannel, .resultWord, .powerState, .cmdValid, .cmdOp,
  .cmdParamOffset, .cmdData, .cmdReady, .apply_bus_addr_cmd);
`default_nettype wire

// ==== tb/srsr_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module srsr_host
  import srsr_pkg::*;
(
  // clock
  input wire logic clock,
  // register port towards the block
  output logic [7:0] regAddr,
  output srsr_pkg::srsr_byte_t regWrData,
  output logic regWrEn,
  output logic regRdEn,
  input wire srsr_pkg::srsr_byte_t regRdData,
  input wire logic regRdValid
);
  import srsr_pkg::*;
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end
  // calls start and end on a falling edge
  task automatic wr(input logic [7:0] a, input srsr_byte_t d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clock);
    regWrEn = 1'b0;
    // released data must not look valid
    regWrData = ~d;
    @(negedge clock);
  endtask
  // prompt read so no later result overwrites it
  task automatic rd(input logic [7:0] a, output srsr_byte_t d, output logic v);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clock);
    d = regRdData;
    v = regRdValid;
    regRdEn = 1'b0;
    @(negedge clock);
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import srsr_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] regAddr;
  srsr_byte_t regWrData, regRdData, apply_bus_addr_cmd, channelEnableList, rdVal;
  logic regWrEn, regRdEn, regRdValid, cmdReady, rdOk;
  logic resultValid = 1'b0;
  srsr_chan_e resultChannel = SRSR_CH_AUX;
  logic [15:0] resultWord = 16'h0000;
  srsr_pwr_e powerState = SRSR_PWR_SLEEP;
  logic cmdValid = 1'b0;
  srsr_op_e cmdOp = SRSR_OP_GET;
  logic [4:0] cmdParamOffset = 5'h00;
  srsr_byte_t cmdData = 8'h00;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [7:0] offs [9] = '{8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h3b, 8'h3c, 8'h3d, 8'h3e};
  always #10 clock = ~clock;
  srsr_result_status_regs u_srsr_result_status_regs(.clock, .rst, .ce, .regAddr, .regWrData, .regWrEn,
    .regRdEn, .regRdData, .regRdValid, .resultValid, .resultChannel, .resultWord, .powerState, .cmdValid,
    .cmdOp, .cmdParamOffset, .cmdData, .cmdReady, .apply_bus_addr_cmd, .channelEnableList);
  srsr_host u_srsr_host(.clock, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .regRdValid);
  task give_verdict;
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task rdchk(input logic [7:0] a, input logic [7:0] exp);
    u_srsr_host.rd(a, rdVal, rdOk);
    chk({7'h00, rdOk, rdVal}, {8'h01, exp});
  endtask
  task res(input srsr_chan_e c, input logic [15:0] w);
    resultChannel = c;
    resultWord = w;
    resultValid = 1'b1;
    @(negedge clock);
  endtask
  // valid is left high so commands can run back to back
  task cmd(input srsr_op_e op, input logic [4:0] off, input srsr_byte_t d);
    cmdOp = op;
    cmdParamOffset = off;
    cmdData = d;
    cmdValid = 1'b1;
    @(negedge clock);
  endtask
  task t_reset;
    foreach (offs[i]) rdchk(offs[i], 8'h00);
    $display("reset values done");
  endtask
  task t_results;
    res(SRSR_CH_PROX3, 16'h1234);
    res(SRSR_CH_AUX, 16'ha55a);
    resultValid = 1'b0;
    rdchk(8'h2d, 8'ha5);
    rdchk(8'h2c, 8'h5a);
    rdchk(8'h2a, 8'h34);
    rdchk(8'h2b, 8'h12);
    u_srsr_host.wr(8'h2b, 8'h77);
    rdchk(8'h2b, 8'h77);
    // a result arriving while ce is low must be dropped
    ce = 1'b0;
    res(SRSR_CH_AUX, 16'hbeef);
    resultValid = 1'b0;
    ce = 1'b1;
    @(negedge clock);
    rdchk(8'h2d, 8'ha5);
    $display("results done");
  endtask
  task t_state;
    for (int i = 0; i < 3; i++) begin
      powerState = srsr_pwr_e'(3'h1 << i);
      @(negedge clock);
      rdchk(8'h30, 8'h01 << i);
    end
    u_srsr_host.wr(8'h30, 8'hff);
    rdchk(8'h30, 8'h04);
    for (int i = 0; i < 4; i++) u_srsr_host.wr(8'h3b + 8'(i), 8'hc0 + 8'(i));
    for (int i = 0; i < 4; i++) rdchk(8'h3b + 8'(i), 8'hc0 + 8'(i));
    rdchk(8'h2f, 8'h00);
    $display("state and key done");
  endtask
  task t_params;
    cmd(SRSR_OP_WRITE, 5'h00, 8'h55);
    chk({8'h00, apply_bus_addr_cmd}, 16'h0000);
    cmd(SRSR_OP_APPLY_ADDR, 5'h00, 8'h00);
    cmdValid = 1'b0;
    chk({8'h00, apply_bus_addr_cmd}, 16'h0055);
    cmd(SRSR_OP_WRITE, 5'h01, 8'h81);
    cmd(SRSR_OP_GET, 5'h00, 8'h00);
    cmdValid = 1'b0;
    for (int i = 0; i < 8 && cmdReady !== 1'b1; i++) @(negedge clock);
    rdchk(8'h2e, 8'h55);
    chk({8'h00, channelEnableList}, 16'h0081);
    rdchk(8'h01, 8'h00);
    $display("parameters done");
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      give_verdict;
    end
  end
  initial begin
    repeat (10) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    t_reset;
    t_results;
    t_state;
    t_params;
    give_verdict;
  end
endmodule
`default_nettype wire
